//--- pkg/psi_consts.vh
// Constants for the power-management status and interrupt-mask block.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef PSI_CONSTS_VH
`define PSI_CONSTS_VH

// ***************************************************************
// Register offsets on the internal register port
// ***************************************************************
`define PSI_OFF_TOP_EVENT_A 8'h20
`define PSI_OFF_TOP_EVENT_B 8'h21
`define PSI_OFF_STEP_EVENT 8'h22
`define PSI_OFF_BOOST_EVENT 8'h23
`define PSI_OFF_DIAG_EVENT 8'h24
`define PSI_OFF_TOP_LIVE 8'h25
`define PSI_OFF_STEP_LIVE 8'h26
`define PSI_OFF_BOOST_LIVE 8'h27
`define PSI_OFF_SUPPLY_LIVE 8'h28
`define PSI_OFF_TOP_MASK_A 8'h29
`define PSI_OFF_TOP_MASK_B 8'h2A
`define PSI_OFF_STEP_MASK 8'h2B
`define PSI_OFF_BOOST_MASK 8'h2C

// ***************************************************************
// Reset values
// ***************************************************************
`define PSI_RST_ZERO 8'h00
`define PSI_RST_TOP_MASK_A 8'h00
`define PSI_RST_TOP_MASK_B 8'h01
`define PSI_RST_STEP_MASK 8'h00
`define PSI_RST_BOOST_MASK 8'h00

// ***************************************************************
// Field positions
// ***************************************************************
// Top event register A and top mask register A.
`define PSI_TOP_MEAS 7
`define PSI_TOP_DIAG_SUM 6
`define PSI_TOP_BOOST_SUM 5
`define PSI_TOP_STEP_SUM 4
`define PSI_TOP_SYNC 3
`define PSI_TOP_TSD 2
`define PSI_TOP_TWARN 1
`define PSI_TOP_OVP 0
// Top event register B and top mask register B.
`define PSI_TOPB_REG_RESET 0
// Step-down live, event and mask registers.
`define PSI_SD_B_EN 7
`define PSI_SD_B_FALL 7
`define PSI_SD_B_GOOD 6
`define PSI_SD_B_RISE 6
`define PSI_SD_B_LIM 4
`define PSI_SD_A_EN 3
`define PSI_SD_A_FALL 3
`define PSI_SD_A_GOOD 2
`define PSI_SD_A_RISE 2
`define PSI_SD_A_LIM 0
// Boost live, event and mask registers.
`define PSI_BST_EN 3
`define PSI_BST_FALL 3
`define PSI_BST_GOOD 2
`define PSI_BST_RISE 2
`define PSI_BST_LIM 0
// Supply monitor live and event registers.
`define PSI_MON_TWO 4
`define PSI_MON_ONE 2
`define PSI_MON_ANA 0

// ***************************************************************
// Live input vector layout (index into the synchronised vector)
// ***************************************************************
`define PSI_LV_WIDTH 16
// Count that the warm-up counter reaches once the synchroniser pipe is full after reset.
`define PSI_SETTLE 2'h3
`define PSI_LV_SYNC_BAD 0
`define PSI_LV_TSD 1
`define PSI_LV_TWARN 2
`define PSI_LV_OVP 3
`define PSI_LV_SDA_EN 4
`define PSI_LV_SDA_GOOD 5
`define PSI_LV_SDA_LIM 6
`define PSI_LV_SDB_EN 7
`define PSI_LV_SDB_GOOD 8
`define PSI_LV_SDB_LIM 9
`define PSI_LV_BST_EN 10
`define PSI_LV_BST_GOOD 11
`define PSI_LV_BST_LIM 12
`define PSI_LV_MON_ONE 13
`define PSI_LV_MON_TWO 14
`define PSI_LV_ANA 15

`endif

//--- rtl/psi_status_irq.v
// Status, latched-event and interrupt-mask registers of the power-management device.
// Assumes a register-access front end on CLK that issues one-cycle read and write
// strobes, analog comparator levels arriving asynchronously, and an external pull-up
// on the open-drain interrupt pin.
`timescale 1ns/1ps
`include "psi_consts.vh"

// Notes on behaviour
// - Monitor-one good change latches diagnostic event bit 2; host writes 1 to clear.
// - Analog-supply good change latches diagnostic event bit 0; write 1 clears it.
// - Top live bit 3 reads 1 while external sync clock is invalid.
// - Top live bit 2 reads 1 while die is above thermal shutdown level.
// - Top live bit 1 reads 1 while die is above thermal warning level.
// - Top live bit 0 shows input overvoltage; bits 7 to 4 read zero.
// - Step-down live bits 7 and 3 show converter b and a enabled.
// - Step-down live bits 6 and 2 show raw output-good of b and a.
// - Step-down live bits 4 and 0 show raw current limit; bits 5, 1 reserved.
// - Boost live bit 3 shows boost enabled; bits 7-4 and 1 reserved.
// - Boost live bit 2 shows raw boost output-good.
// - Boost live bit 0 shows raw boost current limit.
// - Supply live bits 4, 2, 0 show monitor two, one, analog good.
// - Top mask A bit 7 set blocks the measurement-done event.
// - Top mask A bit 3 set blocks sync-clock validity change events.
// - Top mask A bit 1 blocks thermal warning event; live bit unaffected.
// - Top mask B bit 0 blocks register-reset event and resets to one.
// - Step-down mask bits 7, 3 block good-falling events of b, a.
// - Step-down mask bits 6, 2 block good-rising events of b, a.
// - Step-down mask bits 4, 0 block current-limit events of b, a.
// - Boost mask bit 3 blocks good-falling, bit 2 good-rising event.
// - Masks gate only latched flags and interrupt; defaults load from OTP.
// - Diagnostic summary flag clears itself once the diagnostic event register is zero.
// - Boost mask bit 0 blocks boost current-limit event; live bit unaffected.
module psi_status_irq (
   input wire CLK,
   input wire RST_B,
   input wire [7:0] REG_ADDR,
   input wire [7:0] REG_WDATA,
   input wire REG_WR,
   input wire REG_RD,
   output reg [7:0] REG_RDATA,
   input wire OTP_LOAD,
   input wire [7:0] OTP_TOP_MASK_A,
   input wire [7:0] OTP_TOP_MASK_B,
   input wire [7:0] OTP_STEP_MASK,
   input wire [7:0] OTP_BOOST_MASK,
   input wire MEAS_DONE,
   input wire REG_RESET_EVENT,
   input wire SYNC_CLOCK_BAD,
   input wire THERMAL_SHUTDOWN_LIVE,
   input wire THERMAL_WARNING_LIVE,
   input wire INPUT_OVERVOLTAGE_LIVE,
   input wire STEP_DOWN_A_ENABLED_LIVE,
   input wire STEP_DOWN_A_GOOD_LIVE,
   input wire STEP_DOWN_A_LIMIT_LIVE,
   input wire STEP_DOWN_B_ENABLED_LIVE,
   input wire STEP_DOWN_B_GOOD_LIVE,
   input wire STEP_DOWN_B_LIMIT_LIVE,
   input wire BOOST_ENABLED_LIVE,
   input wire BOOST_GOOD_LIVE,
   input wire BOOST_LIMIT_LIVE,
   input wire MONITOR_ONE_GOOD_LIVE,
   input wire MONITOR_TWO_GOOD_LIVE,
   input wire ANALOG_SUPPLY_GOOD_LIVE,
   output wire INTERRUPT_REQUEST_LOW_O,
   output reg INTERRUPT_REQUEST_LOW_OE
);

   // ***************************************************************
   // Input synchronisers
   // ***************************************************************
   wire [`PSI_LV_WIDTH-1:0] live_async;
   reg [`PSI_LV_WIDTH-1:0] live_meta_r;
   reg [`PSI_LV_WIDTH-1:0] live_r;
   reg [`PSI_LV_WIDTH-1:0] live_prev_r;
   reg [1:0] warm_r;
   wire [`PSI_LV_WIDTH-1:0] live_rise;
   wire [`PSI_LV_WIDTH-1:0] live_fall;
   wire [`PSI_LV_WIDTH-1:0] live_edge;

   // Gather the comparator levels into one vector so one synchroniser serves all.
   assign live_async[`PSI_LV_SYNC_BAD] = SYNC_CLOCK_BAD;
   assign live_async[`PSI_LV_TSD] = THERMAL_SHUTDOWN_LIVE;
   assign live_async[`PSI_LV_TWARN] = THERMAL_WARNING_LIVE;
   assign live_async[`PSI_LV_OVP] = INPUT_OVERVOLTAGE_LIVE;
   assign live_async[`PSI_LV_SDA_EN] = STEP_DOWN_A_ENABLED_LIVE;
   assign live_async[`PSI_LV_SDA_GOOD] = STEP_DOWN_A_GOOD_LIVE;
   assign live_async[`PSI_LV_SDA_LIM] = STEP_DOWN_A_LIMIT_LIVE;
   assign live_async[`PSI_LV_SDB_EN] = STEP_DOWN_B_ENABLED_LIVE;
   assign live_async[`PSI_LV_SDB_GOOD] = STEP_DOWN_B_GOOD_LIVE;
   assign live_async[`PSI_LV_SDB_LIM] = STEP_DOWN_B_LIMIT_LIVE;
   assign live_async[`PSI_LV_BST_EN] = BOOST_ENABLED_LIVE;
   assign live_async[`PSI_LV_BST_GOOD] = BOOST_GOOD_LIVE;
   assign live_async[`PSI_LV_BST_LIM] = BOOST_LIMIT_LIVE;
   assign live_async[`PSI_LV_MON_ONE] = MONITOR_ONE_GOOD_LIVE;
   assign live_async[`PSI_LV_MON_TWO] = MONITOR_TWO_GOOD_LIVE;
   assign live_async[`PSI_LV_ANA] = ANALOG_SUPPLY_GOOD_LIVE;

   // Two flops per level; the previous copy feeds edge detection only after them.
   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         live_meta_r <= 16'h0000;
         live_r <= 16'h0000;
         live_prev_r <= 16'h0000;
      end else begin
         live_meta_r <= live_async;
         live_r <= live_meta_r;
         live_prev_r <= live_r;
      end
   end

   // Counts the pipe full after reset, so a level already high at release is no event.
   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         warm_r <= 2'h0;
      end else if (warm_r != `PSI_SETTLE) begin
         warm_r <= warm_r + 2'h1;
      end
   end

   // Edges of the synchronised levels, held off until the warm-up count is reached.
   assign live_rise = live_r & ~live_prev_r & {`PSI_LV_WIDTH{warm_r == `PSI_SETTLE}};
   assign live_fall = ~live_r & live_prev_r & {`PSI_LV_WIDTH{warm_r == `PSI_SETTLE}};
   assign live_edge = live_rise | live_fall;

   // ***************************************************************
   // Register port decode
   // ***************************************************************
   wire wr_top_evt_a = REG_WR && (REG_ADDR == `PSI_OFF_TOP_EVENT_A);
   wire wr_top_evt_b = REG_WR && (REG_ADDR == `PSI_OFF_TOP_EVENT_B);
   wire wr_step_evt = REG_WR && (REG_ADDR == `PSI_OFF_STEP_EVENT);
   wire wr_boost_evt = REG_WR && (REG_ADDR == `PSI_OFF_BOOST_EVENT);
   wire wr_diag_evt = REG_WR && (REG_ADDR == `PSI_OFF_DIAG_EVENT);
   wire wr_top_mask_a = REG_WR && (REG_ADDR == `PSI_OFF_TOP_MASK_A);
   wire wr_top_mask_b = REG_WR && (REG_ADDR == `PSI_OFF_TOP_MASK_B);
   wire wr_step_mask = REG_WR && (REG_ADDR == `PSI_OFF_STEP_MASK);
   wire wr_boost_mask = REG_WR && (REG_ADDR == `PSI_OFF_BOOST_MASK);

   // ***************************************************************
   // Mask registers
   // ***************************************************************
   reg [7:0] top_interrupt_mask_a_r;
   reg [7:0] top_interrupt_mask_b_r;
   reg [7:0] step_down_interrupt_mask_r;
   reg [7:0] boost_interrupt_mask_r;

   // Reset takes constants; the OTP defaults arrive later with OTP_LOAD. A host write
   // in the same cycle as the load wins, since it is the newer intent.
   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         top_interrupt_mask_a_r <= `PSI_RST_TOP_MASK_A;
         top_interrupt_mask_b_r <= `PSI_RST_TOP_MASK_B;
         step_down_interrupt_mask_r <= `PSI_RST_STEP_MASK;
         boost_interrupt_mask_r <= `PSI_RST_BOOST_MASK;
      end else begin
         if (wr_top_mask_a) begin
            top_interrupt_mask_a_r <= REG_WDATA;
         end else if (OTP_LOAD) begin
            top_interrupt_mask_a_r <= OTP_TOP_MASK_A;
         end
         if (wr_top_mask_b) begin
            top_interrupt_mask_b_r <= REG_WDATA;
         end else if (OTP_LOAD) begin
            top_interrupt_mask_b_r <= OTP_TOP_MASK_B;
         end
         if (wr_step_mask) begin
            step_down_interrupt_mask_r <= REG_WDATA;
         end else if (OTP_LOAD) begin
            step_down_interrupt_mask_r <= OTP_STEP_MASK;
         end
         if (wr_boost_mask) begin
            boost_interrupt_mask_r <= REG_WDATA;
         end else if (OTP_LOAD) begin
            boost_interrupt_mask_r <= OTP_BOOST_MASK;
         end
      end
   end

   // ***************************************************************
   // Gated event sources
   // ***************************************************************
   // Masks only decide whether an event latches; the live vector is never touched.
   wire [7:0] ma = top_interrupt_mask_a_r;
   wire [7:0] mb = top_interrupt_mask_b_r;
   wire [7:0] ms = step_down_interrupt_mask_r;
   wire [7:0] mo = boost_interrupt_mask_r;
   reg [7:0] set_top_a;
   reg [7:0] set_top_b;
   reg [7:0] set_step;
   reg [7:0] set_boost;
   reg [7:0] set_diag;

   always @* begin
      set_top_a = 8'h00;
      set_top_b = 8'h00;
      set_step = 8'h00;
      set_boost = 8'h00;
      set_diag = 8'h00;
      set_top_a[`PSI_TOP_MEAS] = MEAS_DONE & ~ma[`PSI_TOP_MEAS];
      set_top_a[`PSI_TOP_SYNC] = live_edge[`PSI_LV_SYNC_BAD] & ~ma[`PSI_TOP_SYNC];
      set_top_a[`PSI_TOP_TSD] = live_rise[`PSI_LV_TSD];
      set_top_a[`PSI_TOP_TWARN] = live_rise[`PSI_LV_TWARN] & ~ma[`PSI_TOP_TWARN];
      set_top_a[`PSI_TOP_OVP] = live_rise[`PSI_LV_OVP];
      set_top_b[`PSI_TOPB_REG_RESET] = REG_RESET_EVENT & ~mb[`PSI_TOPB_REG_RESET];
      set_step[`PSI_SD_B_GOOD] = (live_fall[`PSI_LV_SDB_GOOD] & ~ms[`PSI_SD_B_FALL])
         | (live_rise[`PSI_LV_SDB_GOOD] & ~ms[`PSI_SD_B_RISE]);
      set_step[`PSI_SD_A_GOOD] = (live_fall[`PSI_LV_SDA_GOOD] & ~ms[`PSI_SD_A_FALL])
         | (live_rise[`PSI_LV_SDA_GOOD] & ~ms[`PSI_SD_A_RISE]);
      set_step[`PSI_SD_B_LIM] = live_rise[`PSI_LV_SDB_LIM] & ~ms[`PSI_SD_B_LIM];
      set_step[`PSI_SD_A_LIM] = live_rise[`PSI_LV_SDA_LIM] & ~ms[`PSI_SD_A_LIM];
      set_boost[`PSI_BST_GOOD] = (live_fall[`PSI_LV_BST_GOOD] & ~mo[`PSI_BST_FALL])
         | (live_rise[`PSI_LV_BST_GOOD] & ~mo[`PSI_BST_RISE]);
      set_boost[`PSI_BST_LIM] = live_rise[`PSI_LV_BST_LIM] & ~mo[`PSI_BST_LIM];
      set_diag[`PSI_MON_TWO] = live_edge[`PSI_LV_MON_TWO];
      set_diag[`PSI_MON_ONE] = live_edge[`PSI_LV_MON_ONE];
      set_diag[`PSI_MON_ANA] = live_edge[`PSI_LV_ANA];
   end

   // ***************************************************************
   // Latched event registers
   // ***************************************************************
   reg [7:0] top_event_a_r;
   reg [7:0] top_event_b_r;
   reg [7:0] step_event_r;
   reg [7:0] boost_event_r;
   reg [7:0] diagnostic_event_register_r;
   wire [7:0] top_event_a_nxt;
   wire [7:0] top_event_b_nxt;
   wire [7:0] step_event_nxt;
   wire [7:0] boost_event_nxt;
   wire [7:0] diag_event_nxt;

   // Write-one-to-clear with set winning, so an event in the clearing cycle survives.
   assign top_event_a_nxt = (top_event_a_r & ~(wr_top_evt_a ? REG_WDATA : 8'h00)) | set_top_a;
   assign top_event_b_nxt = (top_event_b_r & ~(wr_top_evt_b ? REG_WDATA : 8'h00)) | set_top_b;
   assign step_event_nxt = (step_event_r & ~(wr_step_evt ? REG_WDATA : 8'h00)) | set_step;
   assign boost_event_nxt = (boost_event_r & ~(wr_boost_evt ? REG_WDATA : 8'h00)) | set_boost;
   assign diag_event_nxt = (diagnostic_event_register_r
      & ~(wr_diag_evt ? REG_WDATA : 8'h00)) | set_diag;

   // Only flag positions ever set, so reserved bits stay zero without extra logic.
   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         top_event_a_r <= `PSI_RST_ZERO;
         top_event_b_r <= `PSI_RST_ZERO;
         step_event_r <= `PSI_RST_ZERO;
         boost_event_r <= `PSI_RST_ZERO;
         diagnostic_event_register_r <= `PSI_RST_ZERO;
      end else begin
         top_event_a_r <= top_event_a_nxt;
         top_event_b_r <= top_event_b_nxt;
         step_event_r <= step_event_nxt;
         boost_event_r <= boost_event_nxt;
         diagnostic_event_register_r <= diag_event_nxt;
      end
   end

   // Summary flags follow their sub-registers, so they clear on their own at zero.
   wire diagnostic_summary_flag = |diagnostic_event_register_r;
   wire boost_summary_flag = |boost_event_r;
   wire step_summary_flag = |step_event_r;
   reg [7:0] top_event_a_view;

   always @* begin
      top_event_a_view = top_event_a_r;
      top_event_a_view[`PSI_TOP_DIAG_SUM] = diagnostic_summary_flag;
      top_event_a_view[`PSI_TOP_BOOST_SUM] = boost_summary_flag;
      top_event_a_view[`PSI_TOP_STEP_SUM] = step_summary_flag;
   end

   // ***************************************************************
   // Live status views
   // ***************************************************************
   reg [7:0] top_live_status;
   reg [7:0] step_down_live_status;
   reg [7:0] boost_live_status;
   reg [7:0] supply_monitor_live_status;

   // Reserved bits are left at zero by the defaults at the top of the process.
   always @* begin
      top_live_status = 8'h00;
      step_down_live_status = 8'h00;
      boost_live_status = 8'h00;
      supply_monitor_live_status = 8'h00;
      top_live_status[`PSI_TOP_SYNC] = live_r[`PSI_LV_SYNC_BAD];
      top_live_status[`PSI_TOP_TSD] = live_r[`PSI_LV_TSD];
      top_live_status[`PSI_TOP_TWARN] = live_r[`PSI_LV_TWARN];
      top_live_status[`PSI_TOP_OVP] = live_r[`PSI_LV_OVP];
      step_down_live_status[`PSI_SD_B_EN] = live_r[`PSI_LV_SDB_EN];
      step_down_live_status[`PSI_SD_A_EN] = live_r[`PSI_LV_SDA_EN];
      step_down_live_status[`PSI_SD_B_GOOD] = live_r[`PSI_LV_SDB_GOOD];
      step_down_live_status[`PSI_SD_A_GOOD] = live_r[`PSI_LV_SDA_GOOD];
      step_down_live_status[`PSI_SD_B_LIM] = live_r[`PSI_LV_SDB_LIM];
      step_down_live_status[`PSI_SD_A_LIM] = live_r[`PSI_LV_SDA_LIM];
      boost_live_status[`PSI_BST_EN] = live_r[`PSI_LV_BST_EN];
      boost_live_status[`PSI_BST_GOOD] = live_r[`PSI_LV_BST_GOOD];
      boost_live_status[`PSI_BST_LIM] = live_r[`PSI_LV_BST_LIM];
      supply_monitor_live_status[`PSI_MON_TWO] = live_r[`PSI_LV_MON_TWO];
      supply_monitor_live_status[`PSI_MON_ONE] = live_r[`PSI_LV_MON_ONE];
      supply_monitor_live_status[`PSI_MON_ANA] = live_r[`PSI_LV_ANA];
   end

   // ***************************************************************
   // Read path
   // ***************************************************************
   reg [7:0] rd_mux;

   // Unmapped offsets read as zero; reads have no side effects on any flag.
   always @* begin
      case (REG_ADDR)
         `PSI_OFF_TOP_EVENT_A: rd_mux = top_event_a_view;
         `PSI_OFF_TOP_EVENT_B: rd_mux = top_event_b_r;
         `PSI_OFF_STEP_EVENT: rd_mux = step_event_r;
         `PSI_OFF_BOOST_EVENT: rd_mux = boost_event_r;
         `PSI_OFF_DIAG_EVENT: rd_mux = diagnostic_event_register_r;
         `PSI_OFF_TOP_LIVE: rd_mux = top_live_status;
         `PSI_OFF_STEP_LIVE: rd_mux = step_down_live_status;
         `PSI_OFF_BOOST_LIVE: rd_mux = boost_live_status;
         `PSI_OFF_SUPPLY_LIVE: rd_mux = supply_monitor_live_status;
         `PSI_OFF_TOP_MASK_A: rd_mux = top_interrupt_mask_a_r;
         `PSI_OFF_TOP_MASK_B: rd_mux = top_interrupt_mask_b_r;
         `PSI_OFF_STEP_MASK: rd_mux = step_down_interrupt_mask_r;
         `PSI_OFF_BOOST_MASK: rd_mux = boost_interrupt_mask_r;
         default: rd_mux = 8'h00;
      endcase
   end

   // Read data is captured on the strobe and held until the next read.
   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         REG_RDATA <= 8'h00;
      end else if (REG_RD) begin
         REG_RDATA <= rd_mux;
      end
   end

   // ***************************************************************
   // Interrupt pin
   // ***************************************************************
   // Masked events never latch, so a flag is unmasked when it latches; the pin ignores masks set later.
   // Registered so the pin does not glitch on the combinational OR.
   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         INTERRUPT_REQUEST_LOW_OE <= 1'b0;
      end else begin
         INTERRUPT_REQUEST_LOW_OE <= (|top_event_a_nxt) | (|top_event_b_nxt)
            | (|step_event_nxt) | (|boost_event_nxt) | (|diag_event_nxt);
      end
   end

   // Open drain: only ever drives low, the pull-up gives the high level.
   assign INTERRUPT_REQUEST_LOW_O = 1'b0;

endmodule // psi_status_irq

//--- test/psi_status_irq_props.sv
// Port checks for the status and interrupt-mask block.
// Assumes a bind onto psi_status_irq, one clock and an async active-low reset.
`timescale 1ns/1ps
module psi_status_irq_props (
   input wire CLK, RST_B, REG_WR, REG_RD,
   input wire [7:0] REG_ADDR, REG_RDATA,
   input wire SYNC_CLOCK_BAD, THERMAL_SHUTDOWN_LIVE, THERMAL_WARNING_LIVE,
   input wire INPUT_OVERVOLTAGE_LIVE, MONITOR_TWO_GOOD_LIVE,
   input wire MONITOR_ONE_GOOD_LIVE, ANALOG_SUPPLY_GOOD_LIVE,
   input wire INTERRUPT_REQUEST_LOW_OE
);
   wire [6:0] lv = {SYNC_CLOCK_BAD, THERMAL_SHUTDOWN_LIVE, THERMAL_WARNING_LIVE,
      INPUT_OVERVOLTAGE_LIVE, MONITOR_TWO_GOOD_LIVE, MONITOR_ONE_GOOD_LIVE,
      ANALOG_SUPPLY_GOOD_LIVE};
   reg [6:0] lv_r;
   reg [2:0] quiet_r;
   // Top and supply live reads are judged only once the synchronisers have settled.
   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         lv_r <= 7'h00;
         quiet_r <= 3'h0;
      end else begin
         lv_r <= lv;
         quiet_r <= (lv != lv_r) ? 3'h0 : quiet_r + {2'h0, quiet_r != 3'h7};
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   a_top_live_bits: assert property (
      REG_RD && REG_ADDR == 8'h25 && quiet_r >= 3'h4 |=> REG_RDATA == {4'h0, $past(lv[6:3])})
      else $error("top live status mismatch");
   a_supply_live_bits: assert property (
      REG_RD && REG_ADDR == 8'h28 && quiet_r >= 3'h4 |=>
      REG_RDATA == {3'h0, $past(lv[2]), 1'b0, $past(lv[1]), 1'b0, $past(lv[0])})
      else $error("supply live status mismatch");
   a_step_reserved_zero: assert property (
      REG_RD && REG_ADDR == 8'h26 |=> (REG_RDATA & 8'h22) == 8'h00)
      else $error("step-down reserved bits set");
   a_boost_reserved_zero: assert property (
      REG_RD && REG_ADDR == 8'h27 |=> (REG_RDATA & 8'hF2) == 8'h00)
      else $error("boost reserved bits set");
   a_unmapped_reads_zero: assert property (
      REG_RD && (REG_ADDR < 8'h20 || REG_ADDR > 8'h2C) |=> REG_RDATA == 8'h00)
      else $error("unmapped read not zero");
   a_irq_falls_on_clear: assert property (
      $fell(INTERRUPT_REQUEST_LOW_OE) |-> $past(REG_WR) && $past(REG_ADDR) >= 8'h20 &&
      $past(REG_ADDR) <= 8'h24)
      else $error("interrupt released without a clearing write");
   a_irq_holds: assert property (
      INTERRUPT_REQUEST_LOW_OE && !REG_WR |=> INTERRUPT_REQUEST_LOW_OE)
      else $error("interrupt dropped without a write");
   a_rdata_stands: assert property (
      !REG_RD |=> $stable(REG_RDATA))
      else $error("read data changed without a read");
endmodule // psi_status_irq_props

//--- test/psi_host.sv
// Host model driving the register strobe port of the block.
// Assumes a strobe is taken at the first rising edge that sees it high.
`timescale 1ns/1ps
module psi_host (
   input wire clk,
   input wire [7:0] rdata,
   output reg [7:0] addr,
   output reg [7:0] wdata,
   output reg wr,
   output reg rd
);
   // Idle lines show the inverse of the last value so nothing stale helps.
   initial begin
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
   end
   task wr8(input [7:0] a, input [7:0] d);
      begin
         @(posedge clk);
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
         @(posedge clk);
         wr <= 1'b0;
         addr <= ~a;
         wdata <= ~d;
      end
   endtask
   task rd8(input [7:0] a, output [7:0] d);
      begin
         @(posedge clk);
         addr <= a;
         rd <= 1'b1;
         @(posedge clk);
         rd <= 1'b0;
         addr <= ~a;
         @(posedge clk);
         d = rdata;
      end
   endtask
endmodule // psi_host

//--- test/psi_status_irq_tb.sv
// Self-checking bench for the status and interrupt-mask block.
// Assumes psi_host as register master and a pull-up on the interrupt pin.
`timescale 1ns/1ps
module psi_status_irq_tb;
   reg clk, rst_b, otp_load, meas_done, rst_ev;
   reg [7:0] otp_a, otp_b, otp_s, otp_o, v;
   reg [15:0] lv;
   wire [7:0] addr, wdata, rdata;
   wire wr, rd, od, oe;
   wire int_pin_b = oe ? od : 1'b1;
   integer err_total, comparisons, i, m;
   psi_host host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
   psi_status_irq uut (.CLK(clk), .RST_B(rst_b), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .OTP_LOAD(otp_load),
      .OTP_TOP_MASK_A(otp_a), .OTP_TOP_MASK_B(otp_b), .OTP_STEP_MASK(otp_s),
      .OTP_BOOST_MASK(otp_o), .MEAS_DONE(meas_done), .REG_RESET_EVENT(rst_ev),
      .SYNC_CLOCK_BAD(lv[0]), .THERMAL_SHUTDOWN_LIVE(lv[1]), .THERMAL_WARNING_LIVE(lv[2]),
      .INPUT_OVERVOLTAGE_LIVE(lv[3]), .STEP_DOWN_A_ENABLED_LIVE(lv[4]),
      .STEP_DOWN_A_GOOD_LIVE(lv[5]), .STEP_DOWN_A_LIMIT_LIVE(lv[6]),
      .STEP_DOWN_B_ENABLED_LIVE(lv[7]), .STEP_DOWN_B_GOOD_LIVE(lv[8]),
      .STEP_DOWN_B_LIMIT_LIVE(lv[9]), .BOOST_ENABLED_LIVE(lv[10]), .BOOST_GOOD_LIVE(lv[11]),
      .BOOST_LIMIT_LIVE(lv[12]), .MONITOR_ONE_GOOD_LIVE(lv[13]),
      .MONITOR_TWO_GOOD_LIVE(lv[14]), .ANALOG_SUPPLY_GOOD_LIVE(lv[15]),
      .INTERRUPT_REQUEST_LOW_O(od), .INTERRUPT_REQUEST_LOW_OE(oe));
   // Expected live register contents from the levels the bench applies.
   function [7:0] live(input [7:0] a);
      case (a)
         8'h25: live = {4'h0, lv[0], lv[1], lv[2], lv[3]};
         8'h26: live = {lv[7], lv[8], 1'b0, lv[9], lv[4], lv[5], 1'b0, lv[6]};
         8'h27: live = {4'h0, lv[10], lv[11], 1'b0, lv[12]};
         default: live = {3'h0, lv[14], 1'b0, lv[13], 1'b0, lv[15]};
      endcase
   endfunction
   task chk(input string nm, input [7:0] seen, input [7:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            err_total = err_total + 1;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task rc(input [7:0] a, input [7:0] e);
      begin
         host.rd8(a, v);
         chk($sformatf("reg %h", a), v, e);
      end
   endtask
   task pin(input p);
      chk("interrupt pin", {7'h0, int_pin_b}, {7'h0, ~p});
   endtask
   // Clearing every event register must also drop the summary and the pin.
   task clr;
      begin
         for (i = 8'h20; i < 8'h25; i = i + 1) host.wr8(i[7:0], 8'hFF);
         rc(8'h20, 8'h00);
         pin(1'b0);
      end
   endtask
   // One source: rise, clear, fall, with expected latched values each way.
   task ev(input integer k, input [7:0] ma, mv, ea, re, fe);
      begin
         host.wr8(ma, mv);
         @(posedge clk) lv[k] <= 1'b1;
         repeat (6) @(posedge clk);
         rc(ea, re);
         if (ea > 8'h21) rc(8'h20, {7'h00, re != 8'h00} << (ea - 8'h1E));
         pin(re != 8'h00);
         host.wr8(ea, 8'hFF);
         @(posedge clk) lv[k] <= 1'b0;
         repeat (6) @(posedge clk);
         rc(ea, fe);
         clr;
      end
   endtask
   task results;
      begin
         $display("comparisons %0d err_total %0d", comparisons, err_total);
         if (err_total == 0 && comparisons > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Watchdog: the sequence needs well under a thousand cycles.
   initial begin
      #(25 * 20000);
      err_total = err_total + 1;
      results;
   end
   initial begin
      {rst_b, otp_load, meas_done, rst_ev} = 4'h0;
      {otp_a, otp_b, otp_s, otp_o} = {8'h82, 8'h01, 8'hC4, 8'h0D};
      lv = 16'h0000;
      err_total = 0;
      comparisons = 0;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      for (m = 8'h1F; m < 8'h2E; m = m + 1) rc(m[7:0], m == 8'h2A ? 8'h01 : 8'h00);
      host.wr8(8'h25, 8'hFF);
      rc(8'h25, 8'h00);
      for (m = 8'h29; m < 8'h2D; m = m + 1) host.wr8(m[7:0], 8'hA5 ^ m[7:0]);
      for (m = 8'h29; m < 8'h2D; m = m + 1) rc(m[7:0], 8'hA5 ^ m[7:0]);
      @(posedge clk) otp_load <= 1'b1;
      @(posedge clk) otp_load <= 1'b0;
      rc(8'h29, otp_a);
      rc(8'h2A, otp_b);
      rc(8'h2B, otp_s);
      rc(8'h2C, otp_o);
      for (m = 8'h29; m < 8'h2D; m = m + 1) host.wr8(m[7:0], 8'hFF);
      for (i = 0; i < 3; i = i + 1) begin
         @(posedge clk) lv <= i == 0 ? 16'hFFFF : (i == 1 ? 16'h5A5A : 16'hA5A5);
         repeat (6) @(posedge clk);
         for (m = 8'h25; m < 8'h29; m = m + 1) rc(m[7:0], live(m[7:0]));
      end
      @(posedge clk) lv <= 16'h0000;
      repeat (6) @(posedge clk);
      clr;
      for (m = 0; m < 2; m = m + 1) begin
         host.wr8(8'h29, m ? 8'h00 : 8'h80);
         host.wr8(8'h2A, m ? 8'h00 : 8'h01);
         @(posedge clk) {meas_done, rst_ev} <= 2'h3;
         @(posedge clk) {meas_done, rst_ev} <= 2'h0;
         rc(8'h20, m ? 8'h80 : 8'h00);
         rc(8'h21, m ? 8'h01 : 8'h00);
         pin(m);
         clr;
      end
      ev(13, 8'h29, 8'h00, 8'h24, 8'h04, 8'h04);
      ev(15, 8'h29, 8'h00, 8'h24, 8'h01, 8'h01);
      ev(2, 8'h29, 8'h02, 8'h20, 8'h00, 8'h00);
      ev(2, 8'h29, 8'h00, 8'h20, 8'h02, 8'h00);
      ev(0, 8'h29, 8'h08, 8'h20, 8'h00, 8'h00);
      ev(0, 8'h29, 8'h00, 8'h20, 8'h08, 8'h08);
      ev(8, 8'h2B, 8'h40, 8'h22, 8'h00, 8'h40);
      ev(5, 8'h2B, 8'h08, 8'h22, 8'h04, 8'h00);
      ev(9, 8'h2B, 8'h10, 8'h22, 8'h00, 8'h00);
      ev(6, 8'h2B, 8'h00, 8'h22, 8'h01, 8'h00);
      ev(11, 8'h2C, 8'h08, 8'h23, 8'h04, 8'h00);
      ev(12, 8'h2C, 8'h01, 8'h23, 8'h00, 8'h00);
      results;
   end
endmodule // psi_status_irq_tb
bind psi_status_irq psi_status_irq_props chk (.CLK, .RST_B, .REG_WR, .REG_RD, .REG_ADDR,
   .REG_RDATA, .SYNC_CLOCK_BAD, .THERMAL_SHUTDOWN_LIVE, .THERMAL_WARNING_LIVE,
   .INPUT_OVERVOLTAGE_LIVE, .MONITOR_TWO_GOOD_LIVE, .MONITOR_ONE_GOOD_LIVE,
   .ANALOG_SUPPLY_GOOD_LIVE, .INTERRUPT_REQUEST_LOW_OE);
